// >>> rtl/margin_map.vh
// constants and register map of the margining code limiter
`ifndef MARGIN_MAP_VH
`define MARGIN_MAP_VH

// ----------------------------------------------------------------
// channel count and register map
// ----------------------------------------------------------------
`define NUM_CH 6
`define NUM_CH_IDX 3'h6
`define REG_CODE 2'h0
`define REG_UPPER 2'h1
`define REG_LOWER 2'h2
`define REG_CTRL 2'h3
`define ADDR_CH_MSB 4
`define ADDR_CH_LSB 2

// ----------------------------------------------------------------
// control / status field layout
// ----------------------------------------------------------------
`define CTRL_EN_BIT 0
`define CTRL_RANGE_LSB 1
`define CTRL_RANGE_MSB 2
`define STAT_INV_BIT 3
`define STAT_DRV_BIT 4
`define CTRL_WR_MASK 8'h07

// ----------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------
`define MIDCODE 8'h7f
`define CODE_RST 8'h7f
`define UPPER_RST 8'h00
`define LOWER_RST 8'hff
`define CTRL_RST 8'h00
`define READ_ZERO 8'h00
`define RANGE_0V60 2'h0
`define RANGE_0V80 2'h1
`define RANGE_1V00 2'h2
`define RANGE_1V25 2'h3

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 100
`define TRACK_SETTLE_NS 10000
`define TRACK_CYCLES ((`TRACK_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_ZERO 8'h00
`define CNT_ONE 8'h01

`endif

// >>> rtl/margin_channel.v
// one margining channel: code clamp and glitch-free buffer enable
`timescale 1ns/10ps
`include "margin_map.vh"

module margin_channel (
  input wire clk, // core clock
  input wire rst, // async reset, high
  input wire [7:0] code, // written margin code
  input wire [7:0] upper, // upper limit
  input wire [7:0] lower, // lower limit
  input wire enable, // channel enable from control
  output reg [7:0] dac_code_reg, // clamped code to converter
  output reg inverted_reg, // limits inverted, buffer held off
  output wire track_en, // buffer powered, following pin
  output wire input_sel_dac, // buffer input switched to converter
  output wire drive_en // buffer output stage on
);

  localparam ST_OFF = 4'b0001;
  localparam ST_TRACK = 4'b0010;
  localparam ST_SWITCH = 4'b0100;
  localparam ST_DRIVE = 4'b1000;

  reg [3:0] st_reg;
  reg [3:0] st_next;
  reg [7:0] cnt_reg;
  reg [7:0] cnt_next;
  wire inv_now;
  wire [31:0] track_last;
  wire [7:0] track_last8;

  assign inv_now = lower > upper;
  assign track_last = `TRACK_CYCLES - 1;
  assign track_last8 = track_last[7:0];

  // unsigned clamp, registered every clock
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      dac_code_reg <= `CODE_RST;
      inverted_reg <= 1'b1;
    end else begin
      inverted_reg <= inv_now;
      if (code < lower) begin
        dac_code_reg <= lower;
      end else if (code > upper) begin
        dac_code_reg <= upper;
      end else begin
        dac_code_reg <= code;
      end
    end
  end

  // buffer enable sequence
  always @* begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    case (st_reg)
      ST_OFF: begin
        cnt_next = `CNT_ZERO;
        if (enable && !inv_now) begin
          st_next = ST_TRACK;
        end
      end
      ST_TRACK: begin
        cnt_next = cnt_reg + `CNT_ONE;
        if (cnt_reg == track_last8) begin
          st_next = ST_SWITCH;
        end
      end
      ST_SWITCH: begin
        st_next = ST_DRIVE;
      end
      ST_DRIVE: begin
        st_next = ST_DRIVE;
      end
      default: begin
        st_next = ST_OFF;
      end
    endcase
    if (!enable || inv_now) begin
      st_next = ST_OFF;
      cnt_next = `CNT_ZERO;
    end
  end

  // state flops
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= ST_OFF;
      cnt_reg <= `CNT_ZERO;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
    end
  end

  assign track_en = ~st_reg[0]; // buffer powered in all but off
  assign input_sel_dac = st_reg[2] | st_reg[3];
  assign drive_en = st_reg[3] & ~inv_now;

endmodule

// >>> rtl/margining_dac_code_limiter.v
// six-channel margining converter code limiter with register file
`timescale 1ns/10ps
`include "margin_map.vh"

module margining_dac_code_limiter (
  input wire clk, // core clock, 10 MHz
  input wire rst, // async reset, high
  input wire host_wr, // register write strobe from bus engine
  input wire host_rd, // register read strobe from bus engine
  input wire [4:0] host_addr, // channel index and register kind
  input wire [7:0] host_wdata, // write data
  output reg [7:0] host_rdata_reg, // read data
  output wire cfg_ready, // low: accesses refused (nack)
  input wire nvm_wr, // startup download write strobe
  input wire [4:0] nvm_addr, // download address
  input wire [7:0] nvm_data, // download data
  input wire nvm_done, // download complete pulse
  output wire [47:0] dac_code, // clamped codes, 8 bits per channel
  output wire [11:0] midcode_offset_voltage, // range select per channel
  output wire [5:0] buf_track_en, // buffer following pin
  output wire [5:0] buf_input_sel_dac, // buffer input on converter
  output wire [5:0] buf_drive_en, // buffer output stage on
  output wire [5:0] limits_inverted // buffer held three-stated
);

  // ----------------------------------------------------------------
  // download gate
  // ----------------------------------------------------------------
  reg done_reg;
  wire w_en;
  wire [4:0] w_addr;
  wire [7:0] w_data;
  wire [2:0] w_ch;
  wire [1:0] w_kind;

  // host locked out until download completes
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      done_reg <= 1'b0;
    end else if (nvm_done) begin
      done_reg <= 1'b1;
    end
  end

  assign cfg_ready = done_reg;

  // one write path: download before ready, host after
  assign w_en = done_reg ? host_wr : nvm_wr;
  assign w_addr = done_reg ? host_addr : nvm_addr;
  assign w_data = done_reg ? host_wdata : nvm_data;
  assign w_ch = w_addr[`ADDR_CH_MSB:`ADDR_CH_LSB];
  assign w_kind = w_addr[1:0];

  // ----------------------------------------------------------------
  // per-channel registers and limiter
  // ----------------------------------------------------------------
  wire [47:0] code_bus;
  wire [47:0] upper_bus;
  wire [47:0] lower_bus;
  wire [47:0] ctrl_bus;
  wire [5:0] drv_bus;

  genvar i;
  generate
    for (i = 0; i < `NUM_CH; i = i + 1) begin : g_ch
      reg [7:0] code_reg;
      reg [7:0] upper_reg;
      reg [7:0] lower_reg;
      reg [7:0] ctrl_reg;
      wire hit;
      wire [2:0] ch_idx;

      localparam [31:0] CH_NUM = i;

      assign ch_idx = CH_NUM[2:0]; // channel number of this slice
      assign hit = w_en && (w_ch == ch_idx);

      // register writes for this channel
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          code_reg <= `CODE_RST;
          upper_reg <= `UPPER_RST;
          lower_reg <= `LOWER_RST;
          ctrl_reg <= `CTRL_RST;
        end else if (hit) begin
          if (w_kind == `REG_CODE) begin
            code_reg <= w_data;
          end else if (w_kind == `REG_UPPER) begin
            upper_reg <= w_data;
          end else if (w_kind == `REG_LOWER) begin
            lower_reg <= w_data;
          end else begin
            ctrl_reg <= w_data & `CTRL_WR_MASK;
          end
        end
      end

      assign code_bus[8*i +: 8] = code_reg;
      assign upper_bus[8*i +: 8] = upper_reg;
      assign lower_bus[8*i +: 8] = lower_reg;
      assign ctrl_bus[8*i +: 8] = ctrl_reg;
      assign midcode_offset_voltage[2*i +: 2] =
        ctrl_reg[`CTRL_RANGE_MSB:`CTRL_RANGE_LSB];

      margin_channel u_chan (
        .clk(clk),
        .rst(rst),
        .code(code_reg),
        .upper(upper_reg),
        .lower(lower_reg),
        .enable(ctrl_reg[`CTRL_EN_BIT]),
        .dac_code_reg(dac_code[8*i +: 8]),
        .inverted_reg(limits_inverted[i]),
        .track_en(buf_track_en[i]),
        .input_sel_dac(buf_input_sel_dac[i]),
        .drive_en(drv_bus[i])
      );
    end
  endgenerate

  assign buf_drive_en = drv_bus;

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  wire [2:0] r_ch;
  wire [1:0] r_kind;
  reg [7:0] rdata_next;
  reg [7:0] stat_byte;

  assign r_ch = host_addr[`ADDR_CH_MSB:`ADDR_CH_LSB];
  assign r_kind = host_addr[1:0];

  // select register, control read shows live status bits
  always @* begin
    stat_byte = ctrl_bus[8*r_ch +: 8];
    stat_byte[`STAT_INV_BIT] = limits_inverted[r_ch];
    stat_byte[`STAT_DRV_BIT] = drv_bus[r_ch];
    if (r_ch >= `NUM_CH_IDX) begin
      rdata_next = `READ_ZERO;
    end else if (r_kind == `REG_CODE) begin
      rdata_next = code_bus[8*r_ch +: 8];
    end else if (r_kind == `REG_UPPER) begin
      rdata_next = upper_bus[8*r_ch +: 8];
    end else if (r_kind == `REG_LOWER) begin
      rdata_next = lower_bus[8*r_ch +: 8];
    end else begin
      rdata_next = stat_byte;
    end
  end

  // read data captured on strobe once ready
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      host_rdata_reg <= `READ_ZERO;
    end else if (host_rd && done_reg) begin
      host_rdata_reg <= rdata_next;
    end
  end

endmodule

// >>> verification/margin_checker_assertions.sv
// concurrent checks on the margining code limiter ports
`timescale 1ns/10ps
module margin_checker (
  input wire clk,
  input wire rst,
  input wire host_wr,
  input wire host_rd,
  input wire [4:0] host_addr,
  input wire [7:0] host_wdata,
  input wire [7:0] host_rdata_reg,
  input wire cfg_ready,
  input wire nvm_wr,
  input wire [4:0] nvm_addr,
  input wire [7:0] nvm_data,
  input wire nvm_done,
  input wire [47:0] dac_code,
  input wire [11:0] midcode_offset_voltage,
  input wire [5:0] buf_track_en,
  input wire [5:0] buf_input_sel_dac,
  input wire [5:0] buf_drive_en,
  input wire [5:0] limits_inverted
);
  reg [7:0] c_reg, u_reg, l_reg, x_reg;
  reg [1:0] r_reg;
  reg i_reg;
  wire w = cfg_ready ? host_wr : nvm_wr;
  wire [4:0] a = cfg_ready ? host_addr : nvm_addr;
  wire [7:0] d = cfg_ready ? host_wdata : nvm_data;
  // shadow of channel 0 registers and its expected clamp
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      c_reg <= 8'h7f;
      u_reg <= 8'h00;
      l_reg <= 8'hff;
      r_reg <= 2'h0;
      x_reg <= 8'h7f;
      i_reg <= 1'b1;
    end else begin
      if (w && a == 5'h00) c_reg <= d;
      if (w && a == 5'h01) u_reg <= d;
      if (w && a == 5'h02) l_reg <= d;
      if (w && a == 5'h03) r_reg <= d[2:1];
      x_reg <= c_reg < l_reg ? l_reg : (c_reg > u_reg ? u_reg : c_reg);
      i_reg <= l_reg > u_reg;
    end
  end
  property p_clamp;
    @(posedge clk) disable iff (rst) dac_code[7:0] == x_reg;
  endproperty
  a_clamp: assert property (p_clamp) else $error("clamped code wrong");
  property p_inv;
    @(posedge clk) disable iff (rst) limits_inverted[0] == i_reg;
  endproperty
  a_inv: assert property (p_inv) else $error("inverted flag wrong");
  property p_off;
    @(posedge clk) disable iff (rst) l_reg > u_reg |-> !buf_drive_en[0];
  endproperty
  a_off: assert property (p_off) else $error("buffer driven with inverted limits");
  property p_ready;
    @(posedge clk) disable iff (rst) (nvm_done || cfg_ready) |=> cfg_ready;
  endproperty
  a_ready: assert property (p_ready) else $error("ready not held");
  property p_range;
    @(posedge clk) disable iff (rst) midcode_offset_voltage[1:0] == r_reg;
  endproperty
  a_range: assert property (p_range) else $error("range select wrong");
  property p_track;
    @(posedge clk) disable iff (rst) $rose(buf_track_en[0]) |-> !buf_input_sel_dac[0] [*8];
  endproperty
  a_track: assert property (p_track) else $error("input switched too early");
  property p_order;
    @(posedge clk) disable iff (rst)
      $rose(buf_drive_en[0]) |-> $past(buf_input_sel_dac[0]) && buf_track_en[0];
  endproperty
  a_order: assert property (p_order) else $error("drive before switch");
  property p_read;
    @(posedge clk) disable iff (rst)
      host_rd && cfg_ready && host_addr == 5'h00 |=> host_rdata_reg == $past(c_reg);
  endproperty
  a_read: assert property (p_read) else $error("code readback wrong");
endmodule
bind margining_dac_code_limiter margin_checker u_chk (.clk, .rst, .host_wr, .host_rd,
  .host_addr, .host_wdata, .host_rdata_reg, .cfg_ready, .nvm_wr, .nvm_addr, .nvm_data,
  .nvm_done, .dac_code, .midcode_offset_voltage, .buf_track_en, .buf_input_sel_dac,
  .buf_drive_en, .limits_inverted);

// >>> verification/mcu_host.sv
// host microcontroller model writing and reading margin registers
`timescale 1ns/10ps
module mcu_host (
  input wire clk, // core clock
  output reg wr = 1'b0, // write strobe
  output reg rd = 1'b0, // read strobe
  output reg [4:0] addr = 5'h00, // register address
  output reg [7:0] wdata = 8'h00, // write data
  input wire [7:0] rdata // read data
);
  // one write, data scrambled once released
  task put(input [4:0] a, input [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~d;
  endtask
  // one read, data taken after the accepting edge
  task get(input [4:0] a, output [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
endmodule

// >>> verification/margining_dac_code_limiter_bench.sv
// self-checking bench of the margining code limiter
`timescale 1ns/10ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module margining_dac_code_limiter_bench;
  reg clk = 1'b0, rst = 1'b1, nvm_wr = 1'b0, nvm_done = 1'b0;
  reg [4:0] nvm_addr = 5'h00;
  reg [7:0] nvm_data = 8'h00, v;
  wire host_wr, host_rd, cfg_ready;
  wire [4:0] host_addr;
  wire [7:0] host_wdata, host_rdata_reg;
  wire [47:0] dac_code;
  wire [11:0] moff;
  wire [5:0] trk, sel, drv, inv;
  int bad_count = 0, checked = 0, i, n;
  reg [39:0] rows [0:6];
  always #50 clk = ~clk;
  margining_dac_code_limiter u_dut (.clk(clk), .rst(rst), .host_wr(host_wr),
    .host_rd(host_rd), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_rdata_reg(host_rdata_reg), .cfg_ready(cfg_ready), .nvm_wr(nvm_wr),
    .nvm_addr(nvm_addr), .nvm_data(nvm_data), .nvm_done(nvm_done), .dac_code(dac_code),
    .midcode_offset_voltage(moff), .buf_track_en(trk), .buf_input_sel_dac(sel),
    .buf_drive_en(drv), .limits_inverted(inv));
  mcu_host u_host (.clk(clk), .wr(host_wr), .rd(host_rd), .addr(host_addr),
    .wdata(host_wdata), .rdata(host_rdata_reg));
  task results;
    if (bad_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // startup download write
  task nload(input [4:0] a, input [7:0] d);
    @(posedge clk);
    nvm_wr <= 1'b1;
    nvm_addr <= a;
    nvm_data <= d;
    @(posedge clk);
    nvm_wr <= 1'b0;
    nvm_data <= ~d;
  endtask
  initial begin
    // channel, lower, upper, code, expected clamp
    rows[0] = {8'h0, 8'h10, 8'hf0, 8'h80, 8'h80};
    rows[1] = {8'h1, 8'h10, 8'hf0, 8'h05, 8'h10};
    rows[2] = {8'h2, 8'h10, 8'hf0, 8'hf5, 8'hf0};
    rows[3] = {8'h3, 8'h00, 8'hff, 8'h00, 8'h00};
    rows[4] = {8'h4, 8'h00, 8'hff, 8'hff, 8'hff};
    rows[5] = {8'h5, 8'h20, 8'h20, 8'h7f, 8'h20};
    rows[6] = {8'h0, 8'h10, 8'hf0, 8'h10, 8'h10};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    #1;
    `CHK("inverted", 6'h3f, inv)
    `CHK("ready", 1'b0, cfg_ready)
    u_host.put(5'h00, 8'h10);
    for (i = 0; i < 6; i++) begin
      nload({i[2:0], 2'h1}, 8'hff);
      nload({i[2:0], 2'h2}, 8'h00);
    end
    @(posedge clk);
    nvm_done <= 1'b1;
    @(posedge clk);
    nvm_done <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("loaded", 6'h00, inv)
    `CHK("ready", 1'b1, cfg_ready)
    u_host.get(5'h00, v);
    `CHK("early write", 8'h7f, v)
    // host steps codes per channel
    for (i = 0; i < 7; i++) begin
      u_host.put({rows[i][34:32], 2'h2}, rows[i][31:24]);
      u_host.put({rows[i][34:32], 2'h1}, rows[i][23:16]);
      u_host.put({rows[i][34:32], 2'h0}, rows[i][15:8]);
      repeat (2) @(posedge clk);
      #1;
      `CHK("clamp", rows[i][7:0], dac_code[rows[i][34:32] * 8 +: 8])
    end
    `CHK("ch1 kept", 8'h10, dac_code[15:8])
    for (i = 0; i < 4; i++) begin
      u_host.put(5'h03, {5'h00, i[1:0], 1'b0});
      #1;
      `CHK("range", i[1:0], moff[1:0])
    end
    u_host.put(5'h03, 8'h01);
    n = 0;
    while (drv[0] !== 1'b1 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK("drive delay", 102, n)
    if (n >= 300) results;
    `CHK("buffer path", 1'b1, sel[0] & trk[0])
    u_host.put(5'h01, 8'h05);
    #1;
    `CHK("buffer off", 1'b0, drv[0])
    u_host.get(5'h03, v);
    `CHK("status", 8'h09, v)
    u_host.get(5'h18, v);
    `CHK("unmapped", 8'h00, v)
    u_host.get(5'h00, v);
    `CHK("readback", 8'h10, v)
    results;
  end
endmodule
